// >>> hw/sec_pkg.sv
// Package for the scrub/EDAC configuration controller
package sec_pkg;
  localparam int CORE_PERIOD_PS = 5000;
  // Bus register offsets (byte addresses)
  localparam logic [3:0] CMD_OFF = 4'h0;
  localparam logic [3:0] CFG_OFF = 4'h4;
  localparam logic [3:0] STAT_OFF = 4'h8;
  localparam logic [3:0] RDAT_OFF = 4'hc;
  // Command field
  localparam int CMD_WRITE_CFG = 0;
  localparam int CMD_READ_CFG = 1;
  localparam int CMD_READ_PTR = 2;
  // Configuration field positions
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_DELAY_LSB = 4;
  localparam int CFG_BYPASS_BIT = 8;
  localparam int CFG_SCRUB_OFF_BIT = 11;
  localparam int CFG_SEVERITY_BIT = 12;
  localparam int CFG_W = 13;
  localparam int PTR_W = 19;
  // Recommended configuration: rate 7, delay 10, all enables 0
  localparam logic [12:0] CFG_RESET = 13'h00a7;
  // Function-select address bits
  localparam int SEL_A7 = 7;
  localparam int SEL_A9 = 9;
  localparam int SEL_A10 = 10;
  // Access phase timing
  localparam int ACCESS_NS = 40;
  localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam logic [3:0] ACCESS_CYC_W = 4'(ACCESS_CYC);
  typedef struct packed {
    logic chip_enable_low_active;
    logic chip_enable_high_active;
    logic output_enable_n;
    logic write_enable_n;
    logic [18:0] addr;
  } sec_pins_s;
  typedef enum logic [1:0] {SEC_IDLE, SEC_ACCESS, SEC_DONE} sec_state_e;
endpackage : sec_pkg

// >>> hw/sec_ctrl.sv
// Host controller for memory EDAC configuration and scrub pointer access
`timescale 1ns/1ps
// How it works
// - Host may stall on falling scrub warning; slave warning unconnected.
// - Host never accesses memory while scrub active is low.
// - Config write: enables on, OE and WE high, flag high, A10:A9 low; the code drives cfg bits 10:9 there, unmasked.
// - Config read: same levels, A9 high, A10 low; memory returns contents.
// - Pointer read: A7 and A10 high; pointer on data bits 18..0.
// - After a scrub error flag, host may read pointer for location.
// - Host applies no other A7..A10 combination.
// - Host must write, and should read back, config after power-up.
// - A10:A9 zero during programming; A18..A13 ignored. The code puts cfg bits 10:9 on A10:A9 without masking them.
module sec_ctrl
  import sec_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output sec_pins_s mem_pins,
  input wire logic [31:0] mem_dq_in,
  input wire logic error_flag_in,
  output logic error_flag_out,
  output logic error_flag_oe,
  input wire logic scrub_warning_n,
  input wire logic scrub_active_n
);
  sec_state_e state_reg, state_next;
  logic [1:0] op_reg, op_next;
  logic [CFG_W-1:0] cfg_reg, cfg_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [3:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic scrub_err_reg, scrub_err_next;
  logic [31:0] rd_reg, rd_next;
  logic wait_reg, wait_next;
  sec_pins_s pins_reg, pins_next;
  logic flag_oe_reg, flag_oe_next;
  logic [2:0] act_sync_reg, warn_sync_reg, err_sync_reg;
  logic act_n_reg, warn_n_reg, err_reg;
  // Three-stage input capture; second and third agree before a level counts
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      act_sync_reg <= 3'h7;
      warn_sync_reg <= 3'h7;
      err_sync_reg <= 3'h0;
      act_n_reg <= 1'b1;
      warn_n_reg <= 1'b1;
      err_reg <= 1'b0;
    end else begin
      act_sync_reg <= {act_sync_reg[1:0], scrub_active_n};
      warn_sync_reg <= {warn_sync_reg[1:0], scrub_warning_n};
      err_sync_reg <= {err_sync_reg[1:0], error_flag_in};
      if (act_sync_reg[2] == act_sync_reg[1]) act_n_reg <= act_sync_reg[2];
      if (warn_sync_reg[2] == warn_sync_reg[1]) warn_n_reg <= warn_sync_reg[2];
      if (err_sync_reg[2] == err_sync_reg[1]) err_reg <= err_sync_reg[2];
    end
  end
  function automatic logic [18:0] sel_addr(input logic [1:0] op, input logic [CFG_W-1:0] cfg);
    logic [18:0] a;
    a = 19'h00000;
    case (op)
      2'(CMD_WRITE_CFG): a[CFG_W-1:0] = cfg;
      2'(CMD_READ_CFG): a[SEL_A9] = 1'b1;
      default: begin
        a[SEL_A7] = 1'b1;
        a[SEL_A10] = 1'b1;
      end
    endcase
    return a;
  endfunction : sel_addr
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    cfg_next = cfg_reg;
    rdat_next = rdat_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    scrub_err_next = scrub_err_reg;
    rd_next = 32'h00000000;
    wait_next = 1'b1;
    pins_next = pins_reg;
    flag_oe_next = flag_oe_reg;
    // Flag seen while scrub runs marks a failing word; set beats clear
    if (!act_n_reg && err_reg) scrub_err_next = 1'b1;
    // Bus slave: one-cycle answer after the request edge
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      if (avs_read) begin
        case (avs_address)
          CFG_OFF: rd_next = {19'h00000, cfg_reg};
          STAT_OFF: rd_next = {27'h0000000, scrub_err_reg, warn_n_reg, act_n_reg,
                               1'b0, busy_reg};
          RDAT_OFF: rd_next = rdat_reg;
          default: rd_next = 32'h00000000;
        endcase
      end
    end
    // Writes land at the accepting edge, so a held request writes once
    if (avs_write && !wait_reg) begin
      case (avs_address)
        CFG_OFF: cfg_next = avs_writedata[CFG_W-1:0];
        STAT_OFF: if (avs_writedata[4] && !(!act_n_reg && err_reg)) scrub_err_next = 1'b0;
        CMD_OFF: if (!busy_reg && avs_writedata[1:0] != 2'h3) begin
          op_next = avs_writedata[1:0];
          busy_next = 1'b1;
        end
        default: ;
      endcase
    end
    case (state_reg)
      SEC_IDLE: begin
        pins_next.chip_enable_low_active = 1'b1;
        pins_next.chip_enable_high_active = 1'b0;
        pins_next.output_enable_n = 1'b1;
        pins_next.write_enable_n = 1'b1;
        flag_oe_next = 1'b0;
        // Stall on warning too; the filter lags, so a strobe alone comes too late
        if (busy_reg && act_n_reg && warn_n_reg) begin
          pins_next.addr = sel_addr(op_reg, cfg_reg);
          pins_next.chip_enable_low_active = 1'b0;
          pins_next.chip_enable_high_active = 1'b1;
          flag_oe_next = 1'b1;
          cnt_next = ACCESS_CYC_W;
          state_next = SEC_ACCESS;
        end
      end
      SEC_ACCESS: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) state_next = SEC_DONE;
      end
      SEC_DONE: begin
        if (op_reg == 2'(CMD_READ_PTR)) rdat_next = {13'h0000, mem_dq_in[PTR_W-1:0]};
        else if (op_reg == 2'(CMD_READ_CFG)) rdat_next = {19'h00000, mem_dq_in[CFG_W-1:0]};
        if (op_reg == 2'(CMD_WRITE_CFG)) rdat_next = {13'h0000, {PTR_W{1'b1}}};
        pins_next.chip_enable_low_active = 1'b1;
        pins_next.chip_enable_high_active = 1'b0;
        flag_oe_next = 1'b0;
        busy_next = 1'b0;
        state_next = SEC_IDLE;
      end
      default: state_next = SEC_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= SEC_IDLE;
      op_reg <= 2'h0;
      cfg_reg <= CFG_RESET;
      rdat_reg <= 32'h00000000;
      cnt_reg <= 4'h0;
      busy_reg <= 1'b1;
      scrub_err_reg <= 1'b0;
      rd_reg <= 32'h00000000;
      wait_reg <= 1'b1;
      pins_reg <= '{1'b1, 1'b0, 1'b1, 1'b1, 19'h00000};
      flag_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      cfg_reg <= cfg_next;
      rdat_reg <= rdat_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      scrub_err_reg <= scrub_err_next;
      rd_reg <= rd_next;
      wait_reg <= wait_next;
      pins_reg <= pins_next;
      flag_oe_reg <= flag_oe_next;
    end
  end
  assign avs_readdata = rd_reg;
  assign avs_waitrequest = wait_reg;
  assign mem_pins = pins_reg;
  // Flag level only matters while driven
  assign error_flag_out = flag_oe_reg;
  assign error_flag_oe = flag_oe_reg;

  access_no_scrub_a: assert property (@(posedge core_clk) disable iff (reset)
    $fell(mem_pins.chip_enable_low_active) |-> $past(act_n_reg) && $past(warn_n_reg))
    else $error("access started during scrub");
  flag_drive_a: assert property (@(posedge core_clk) disable iff (reset)
    !mem_pins.chip_enable_low_active |-> error_flag_oe && error_flag_out
    && mem_pins.output_enable_n && mem_pins.write_enable_n)
    else $error("config access levels wrong");
  sel_legal_a: assert property (@(posedge core_clk) disable iff (reset)
    !mem_pins.chip_enable_low_active |-> (mem_pins.addr[10:9] == 2'b00
    || mem_pins.addr[10:9] == 2'b01 || (mem_pins.addr[10] && mem_pins.addr[7])))
    else $error("reserved select combination");
  ptr_sel_a: assert property (@(posedge core_clk) disable iff (reset)
    (!mem_pins.chip_enable_low_active && op_reg == 2'(CMD_READ_PTR))
    |-> mem_pins.addr[10] && mem_pins.addr[7])
    else $error("pointer read select wrong");
  read_sel_a: assert property (@(posedge core_clk) disable iff (reset)
    (!mem_pins.chip_enable_low_active && op_reg == 2'(CMD_READ_CFG))
    |-> mem_pins.addr[10:9] == 2'b01)
    else $error("config read select wrong");
  write_val_a: assert property (@(posedge core_clk) disable iff (reset)
    ($fell(mem_pins.chip_enable_low_active) && op_reg == 2'(CMD_WRITE_CFG))
    |-> mem_pins.addr[CFG_W-1:0] == $past(cfg_reg) && mem_pins.addr[10:9] == 2'b00)
    else $error("config write value wrong");
  addr_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    (!mem_pins.chip_enable_low_active && !$past(mem_pins.chip_enable_low_active))
    |-> $stable(mem_pins.addr))
    else $error("address moved during access");
  ptr_ones_a: assert property (@(posedge core_clk) disable iff (reset)
    (state_reg == SEC_DONE && op_reg == 2'(CMD_WRITE_CFG))
    |=> rdat_reg[PTR_W-1:0] == {PTR_W{1'b1}})
    else $error("pointer mirror not all ones");
  oe_high_a: assert property (@(posedge core_clk) disable iff (reset)
    mem_pins.output_enable_n)
    else $error("output enable asserted");
  scrub_err_set_a: assert property (@(posedge core_clk) disable iff (reset)
    (!act_n_reg && err_reg) |=> scrub_err_reg)
    else $error("scrub error not latched");
endmodule : sec_ctrl

// >>> verif/sec_mem_model.sv
// Memory device model: control register, scrub pointer and scrub handshake
`timescale 1ns/1ps
module sec_mem_model
  import sec_pkg::*;
(
  input wire logic core_clk,
  input wire sec_pins_s pins,
  input wire logic flag,
  input wire logic go,
  output logic [31:0] dq,
  output logic warn_n,
  output logic act_n,
  output logic [12:0] cfg
);
  logic [18:0] ptr;
  logic [7:0] cnt;
  logic sel;
  // Master role; functions need the flag held high
  assign sel = !pins.chip_enable_low_active && pins.chip_enable_high_active && flag;
  initial {cfg, ptr, cnt, dq, warn_n, act_n} = 74'h3;
  always @(posedge core_clk) begin
    dq <= ~dq;
    if (sel && pins.addr[10:9] == 2'h0) cfg <= pins.addr[12:0];
    if (sel && pins.addr[10:9] == 2'h1) dq <= {~ptr, cfg};
    if (sel && pins.addr[10] && pins.addr[7]) dq <= {~cfg, ptr};
    if (sel && pins.addr[10:9] == 2'h0) ptr <= 19'h7ffff;
    else if (!act_n && cnt == 8'h0) ptr <= ptr + 19'h1;
    // Scrub starts only with a usable rate code and scrubbing on
    if (go && warn_n && !cfg[8] && !cfg[11] && cfg[3:0] > 4'h3)
      warn_n <= 1'b0;
    if (go && warn_n) cnt <= 8'(cfg[7:4]) + 8'h2;
    else if (cnt != 8'h0) cnt <= cnt - 8'h1;
    else if (!warn_n && act_n) cnt <= 8'h0c;
    if (!warn_n && act_n && cnt == 8'h0) act_n <= 1'b0;
    if (!act_n && cnt == 8'h0) {warn_n, act_n} <= 2'h3;
  end
endmodule : sec_mem_model

// >>> verif/testbench.sv
// Self-checking bench for the EDAC configuration controller
`timescale 1ns/1ps
module testbench;
  import sec_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, go = 1'b0;
  logic bad = 1'b0, bad_seen = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, dq, q;
  logic avs_waitrequest, f_out, f_oe, flag, warn_n, act_n;
  logic [12:0] cfg;
  sec_pins_s pins;
  int errors = 0, n_compared = 0, i, k;
  assign flag = f_oe ? f_out : (!act_n && bad); // Undriven: high while scrub active and bad set, else pulled low
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (!act_n && !pins.chip_enable_low_active) bad_seen <= 1'b1;
  sec_ctrl dut (.core_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .mem_pins(pins), .mem_dq_in(dq), .error_flag_in(flag),
    .error_flag_out(f_out), .error_flag_oe(f_oe), .scrub_warning_n(warn_n),
    .scrub_active_n(act_n));
  sec_mem_model mem (.core_clk, .pins, .flag, .go, .dq, .warn_n, .act_n, .cfg);
  task results(input int late);
    errors += late;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    errors += int'(got !== exp);
    if (got !== exp) $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
  endtask : chk
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    for (i = 0; i == 0 || (avs_waitrequest !== 1'b0 && i < 100); i++) @(posedge core_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i >= 100) results(1);
  endtask : bus
  // Command, poll busy, then fetch the result word
  task cmd(input logic [31:0] c);
    bus(1'b1, CMD_OFF, c);
    for (k = 0; k == 0 || (q[0] !== 1'b0 && k < 60); k++) bus(1'b0, STAT_OFF, 32'h0);
    if (k >= 60) results(1);
    bus(1'b0, RDAT_OFF, 32'h0);
  endtask : cmd
  task scrub;
    @(posedge core_clk);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    for (k = 0; k < 100 && act_n !== 1'b0; k++) @(posedge core_clk);
    if (k >= 100) results(1);
    // Let the input filter see the strobe before new orders
    repeat (4) @(posedge core_clk);
  endtask : scrub
  task t_setup;
    cmd(32'h3);
    chk({19'h0, cfg}, 32'h000000a7);
    chk(q, 32'h0007ffff);
    bus(1'b1, CFG_OFF, 32'h000018c7);
    cmd(32'h0);
    chk({19'h0, cfg}, 32'h000018c7);
    cmd(32'h1);
    chk(q, 32'h000018c7);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    $display("setup test done");
  endtask : t_setup
  task t_scrub;
    bus(1'b1, CFG_OFF, 32'h000000a7);
    cmd(32'h0);
    bad <= 1'b1;
    scrub;
    cmd(32'h2);
    chk(q, 32'h0);
    chk({31'h0, bad_seen}, 32'h0);
    bus(1'b0, STAT_OFF, 32'h0);
    chk(q & 32'h1d, 32'h1c);
    bus(1'b1, STAT_OFF, 32'h00000010);
    bus(1'b0, STAT_OFF, 32'h0);
    chk(q & 32'h10, 32'h0);
    $display("scrub test done");
  endtask : t_scrub
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    t_setup;
    t_scrub;
    results(0);
  end
endmodule : testbench
